// ===== logic/listen_channel_ring_store.sv
// listen channel ring store: stores every valid frame into the upper
// ring of message buffers, keeps the last-stored index, drives mirroring
// assumes frames, clear and completion events come on the same clock
//
// Contract
// - store every valid frame in upper sixteen, unfiltered
// - next higher free buffer, wrap 47 to 32
// - mirror reception sets new data, no interrupt
// - engine evaluated on every transmit request clear
// - cleared request advances to next pending slot
// - mirror transmit success clears new data flag
// - no history list; last-stored index register
// - last index kept in stop, cleared entering init
// - stores never move the history get pointer
// - remote frames stored like data, remote bit set
// - extended bit written from received format
// - store only if assigned listen and ready
// - transmit-type buffers still receive frames
// - storing pointer to buffer 32 on reassign
// - data, length, identifier written as received
// - overflow bit set when slot still full
// - init exit starts at 32, sleep resumes
// - never overwrite full slot, resume when cleared
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module listen_channel_ring_store (
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  // register port
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr_en,
  input  wire logic                   i_rd_en,
  output logic [31:0]                 o_rdata,
  // receiving protocol engine
  input  wire logic                   i_rx_valid,
  input  wire ring_store_pkg::frame_t i_rx_frame,
  // shared buffer configuration
  input  wire logic [15:0][2:0]       i_assign,
  input  wire logic                   i_reassign,
  // diagnosis channel
  input  wire logic                   i_trq_clr,
  input  wire logic [5:0]             i_trq_clr_idx,
  input  wire logic                   i_tx_done,
  input  wire logic [5:0]             i_tx_done_idx,
  // buffer write and status
  output ring_store_pkg::store_t      o_store,
  output logic [15:0]                 o_new_data,
  output logic [15:0]                 o_trq,
  output logic                        o_rx_event
);

  // **********************************************
  // state
  // **********************************************
  logic [2:0]  mode;
  logic [1:0]  ps;
  logic [15:0] ready;
  logic [3:0]  ptr;
  logic [5:0]  last;
  logic        ovf;
  logic [2:0]  next_mode;
  logic [1:0]  next_ps;
  logic [15:0] next_ready;
  logic [15:0] next_dn;
  logic [15:0] next_trq;
  logic [3:0]  next_ptr;
  logic [5:0]  next_last;
  logic        next_ovf;
  ring_store_pkg::store_t next_store;
  logic        next_rx_event;
  logic [31:0] next_rdata;

  logic        is_init;
  logic        active;
  logic        listen_mode;
  logic        mirror_on;
  logic        store_go;
  logic        overflow_ev;
  logic        wr_ctrl;
  logic        wr_trq;
  logic        enter_init;
  logic        cur_cleared;
  logic        eval;
  logic [15:0] dn_clr;
  logic [15:0] trq_clr;
  logic [15:0] trq_set;
  logic        eng_set;
  logic [3:0]  eng_idx;
  logic [3:0]  eng_cur;
  logic        eng_busy;

  function automatic logic [15:0] one_hot(input logic [3:0] slot);
    return 16'h0001 << slot;
  endfunction

  function automatic logic in_ring(input logic [5:0] num);
    return num >= ring_store_pkg::RING_BASE;
  endfunction

  // **********************************************
  // decode
  // **********************************************
  always_comb begin
    is_init     = (mode == ring_store_pkg::OP_INIT);
    active      = !is_init && (ps == ring_store_pkg::PS_NONE);
    listen_mode = (mode == ring_store_pkg::OP_RX_ONLY)
               || (mode == ring_store_pkg::OP_MIRROR)
               || (mode == ring_store_pkg::OP_MIRROR_TIF);
    mirror_on   = active && ((mode == ring_store_pkg::OP_MIRROR)
               || (mode == ring_store_pkg::OP_MIRROR_TIF));
    // store only at the slot of the storing pointer; type field not checked
    store_go    = i_rx_valid && active && listen_mode
               && (i_assign[ptr] == ring_store_pkg::ASSIGN_LISTEN)
               && ready[ptr]
               && !o_new_data[ptr];
    overflow_ev = i_rx_valid && active && listen_mode
               && o_new_data[ptr];
    wr_ctrl     = i_wr_en && (i_addr == ring_store_pkg::REG_CTRL);
    wr_trq      = i_wr_en && (i_addr == ring_store_pkg::REG_TRQ);
    next_mode   = wr_ctrl ? i_wdata[ring_store_pkg::CTRL_MODE_LSB +: 3]
                          : mode;
    next_ps     = wr_ctrl ? i_wdata[ring_store_pkg::CTRL_PS_LSB +: 2] : ps;
    enter_init  = (next_mode == ring_store_pkg::OP_INIT) && !is_init;
    // any clear, lower buffers included, wakes the mirror engine
    eval        = i_trq_clr || (wr_trq && (i_wdata[15:0] != 16'h0000));
    cur_cleared = (i_trq_clr
                   && i_trq_clr_idx == ring_store_pkg::buf_num(eng_cur))
               || (wr_trq && i_wdata[eng_cur]);
  end

  // **********************************************
  // next values
  // **********************************************
  always_comb begin
    next_ready = ready;
    if (i_wr_en && i_addr == ring_store_pkg::REG_READY) begin
      next_ready = i_wdata[15:0];
    end

    // storing pointer and last index; neither touched by sleep or stop
    next_ptr  = ptr;
    next_last = last;
    if (enter_init || i_reassign) begin
      next_ptr = ring_store_pkg::RST_PTR;
    end else if (store_go) begin
      next_ptr = ptr + 4'h1;
    end
    if (enter_init) begin
      next_last = ring_store_pkg::RST_LAST;
    end else if (store_go) begin
      next_last = ring_store_pkg::buf_num(ptr);
    end

    // new data flags: a set in the same cycle wins over any clear
    dn_clr = 16'h0000;
    if (i_wr_en && i_addr == ring_store_pkg::REG_NEW_DATA) begin
      dn_clr = i_wdata[15:0];
    end
    if (mirror_on && i_tx_done && in_ring(i_tx_done_idx)) begin
      dn_clr = dn_clr | one_hot(i_tx_done_idx[3:0]);
    end
    next_dn = (o_new_data & ~dn_clr)
            | (store_go ? one_hot(ptr) : 16'h0000);

    // transmit requests of the ring are raised only by the engine
    trq_clr = wr_trq ? i_wdata[15:0] : 16'h0000;
    if (i_trq_clr && in_ring(i_trq_clr_idx)) begin
      trq_clr = trq_clr | one_hot(i_trq_clr_idx[3:0]);
    end
    trq_set  = (eng_set && mirror_on) ? one_hot(eng_idx) : 16'h0000;
    next_trq = (o_trq & ~trq_clr) | trq_set;

    next_ovf = ovf;
    if (i_wr_en && i_addr == ring_store_pkg::REG_STATUS
        && i_wdata[ring_store_pkg::STAT_OVF_BIT]) begin
      next_ovf = 1'b0;
    end
    if (overflow_ev) begin
      next_ovf = 1'b1;
    end

    // frame goes out as received; history get pointer has no port here
    next_store.valid = store_go;
    next_store.index = ring_store_pkg::buf_num(ptr);
    next_store.frame = i_rx_frame;
    next_rx_event    = store_go
                    && (mode == ring_store_pkg::OP_RX_ONLY);

    next_rdata = 32'h0000_0000;
    if (i_rd_en) begin
      case (i_addr)
        ring_store_pkg::REG_CTRL:
          next_rdata = {26'h0, ps, 1'b0, mode};
        ring_store_pkg::REG_STATUS:
          next_rdata = {29'h0, active, eng_busy, ovf};
        ring_store_pkg::REG_LAST:
          next_rdata = {26'h0, last};
        ring_store_pkg::REG_NEW_DATA:
          next_rdata = {16'h0, o_new_data};
        ring_store_pkg::REG_TRQ:
          next_rdata = {16'h0, o_trq};
        ring_store_pkg::REG_READY:
          next_rdata = {16'h0, ready};
        ring_store_pkg::REG_STORE_PTR:
          next_rdata = {26'h0, ring_store_pkg::buf_num(ptr)};
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // **********************************************
  // registers
  // **********************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode       <= ring_store_pkg::OP_INIT;
      ps         <= ring_store_pkg::PS_NONE;
      ready      <= 16'h0000;
      ptr        <= ring_store_pkg::RST_PTR;
      last       <= ring_store_pkg::RST_LAST;
      ovf        <= 1'b0;
      o_new_data <= 16'h0000;
      o_trq      <= 16'h0000;
      o_store    <= '0;
      o_rx_event <= 1'b0;
      o_rdata    <= 32'h0000_0000;
    end else begin
      mode       <= next_mode;
      ps         <= next_ps;
      ready      <= next_ready;
      ptr        <= next_ptr;
      last       <= next_last;
      ovf        <= next_ovf;
      o_new_data <= next_dn;
      o_trq      <= next_trq;
      o_store    <= next_store;
      o_rx_event <= next_rx_event;
      o_rdata    <= next_rdata;
    end
  end

  // **********************************************
  // mirror engine
  // **********************************************
  mirror_engine u_mirror (
    .i_mclk        (i_mclk),
    .i_rst_n       (i_rst_n),
    .i_enable      (mirror_on),
    .i_stored      (store_go && mirror_on),
    .i_stored_idx  (ptr),
    .i_eval        (eval),
    .i_cur_cleared (cur_cleared),
    .o_set_trq     (eng_set),
    .o_set_idx     (eng_idx),
    .o_cur         (eng_cur),
    .o_busy        (eng_busy)
  );

  // **********************************************
  // checks
  // **********************************************
  property p_ring_slot;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_store.valid |-> (o_store.index == {2'h2, $past(ptr)});
  endproperty
  a_ring_slot: assert property (p_ring_slot)
    else $error("frame stored outside the ring order");

  property p_full_slot;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_rx_valid && active && listen_mode && o_new_data[ptr])
    |=> (!o_store.valid && ovf);
  endproperty
  a_full_slot: assert property (p_full_slot)
    else $error("full slot written or overflow not flagged");

  property p_last_follows;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_store.valid |-> (last == o_store.index
                       && o_new_data[o_store.index[3:0]]);
  endproperty
  a_last_follows: assert property (p_last_follows)
    else $error("last index or new data flag not updated");

  property p_as_received;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_store.valid |-> (o_store.frame == $past(i_rx_frame));
  endproperty
  a_as_received: assert property (p_as_received)
    else $error("stored frame differs from received frame");

  property p_init_clear;
    @(posedge i_mclk) disable iff (!i_rst_n)
    $rose(is_init) |-> (last == ring_store_pkg::RST_LAST
                        && ptr == ring_store_pkg::RST_PTR);
  endproperty
  a_init_clear: assert property (p_init_clear)
    else $error("pointers not cleared on init entry");

  property p_no_mirror_irq;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_rx_event |-> ($past(mode) == ring_store_pkg::OP_RX_ONLY);
  endproperty
  a_no_mirror_irq: assert property (p_no_mirror_irq)
    else $error("receive event outside receive-only mode");

  property p_auto_clear;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (mirror_on && i_tx_done && in_ring(i_tx_done_idx)
     && !(store_go && ptr == i_tx_done_idx[3:0]))
    |=> !o_new_data[$past(i_tx_done_idx[3:0])];
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("new data flag not cleared after mirror transmit");

  property p_reassign;
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_reassign |=> (ptr == ring_store_pkg::RST_PTR);
  endproperty
  a_reassign: assert property (p_reassign)
    else $error("storing pointer not reset on reassignment");

  property p_unassigned;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_assign[ptr] != ring_store_pkg::ASSIGN_LISTEN || !ready[ptr])
    |=> !o_store.valid;
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("frame stored into unassigned or unready buffer");

endmodule // listen_channel_ring_store

// ===== logic/ring_store_pkg.sv
// constants, field layouts and carriers for the listen channel ring store
// assumes one clock domain shared with the receiving protocol engine
package ring_store_pkg;

  // **********************************************
  // buffer geometry
  // **********************************************
  localparam int          BUF_COUNT  = 48;
  localparam int          RING_SIZE  = 16;
  localparam logic [5:0]  RING_BASE  = 6'(BUF_COUNT - RING_SIZE);
  localparam logic [2:0]  ASSIGN_LISTEN = 3'h1;

  // **********************************************
  // register offsets (byte addresses)
  // **********************************************
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_LAST      = 8'h08;
  localparam logic [7:0]  REG_NEW_DATA  = 8'h0c;
  localparam logic [7:0]  REG_TRQ       = 8'h10;
  localparam logic [7:0]  REG_READY     = 8'h14;
  localparam logic [7:0]  REG_STORE_PTR = 8'h18;

  // **********************************************
  // field positions and codes
  // **********************************************
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_PS_LSB   = 4;
  localparam int          STAT_OVF_BIT  = 0;
  localparam int          STAT_BUSY_BIT = 1;
  localparam int          STAT_ACT_BIT  = 2;
  localparam logic [2:0]  OP_INIT       = 3'h0;
  localparam logic [2:0]  OP_RX_ONLY    = 3'h1;
  localparam logic [2:0]  OP_MIRROR     = 3'h2;
  localparam logic [2:0]  OP_MIRROR_TIF = 3'h3;
  localparam logic [1:0]  PS_NONE       = 2'h0;
  localparam logic [1:0]  PS_SLEEP      = 2'h1;
  localparam logic [1:0]  PS_STOP       = 2'h2;

  // **********************************************
  // reset values
  // **********************************************
  localparam logic [3:0]  RST_PTR     = 4'h0;
  localparam logic [5:0]  RST_LAST    = 6'h00;
  localparam logic [4:0]  RST_PENDING = 5'h00;

  // **********************************************
  // carriers
  // **********************************************
  typedef struct packed {
    logic [28:0] ident;
    logic        ext_ident;
    logic        remote;
    logic [3:0]  length;
    logic [63:0] data;
  } frame_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] index;
    frame_t     frame;
  } store_t;

  function automatic logic [5:0] buf_num(input logic [3:0] slot);
    return RING_BASE + {2'h0, slot};
  endfunction

endpackage

// ===== logic/mirror_engine.sv
// mirror engine: hands stored ring slots one at a time to the diagnosis
// channel by raising one transmit request flag at a time
// assumes request clears are reported to it by the enclosing store block
`timescale 1ns/1ps
module mirror_engine (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // control
  input  wire logic       i_enable,
  input  wire logic       i_stored,
  input  wire logic [3:0] i_stored_idx,
  input  wire logic       i_eval,
  input  wire logic       i_cur_cleared,
  // results
  output logic            o_set_trq,
  output logic [3:0]      o_set_idx,
  output logic [3:0]      o_cur,
  output logic            o_busy
);

  typedef enum logic {ST_IDLE, ST_BUSY} eng_state_t;

  eng_state_t state;
  eng_state_t next_state;
  logic [4:0] pending;
  logic [4:0] next_pending;
  logic [3:0] next_cur;
  logic       next_set_trq;
  logic [3:0] next_set_idx;

  // **********************************************
  // next state
  // **********************************************
  always_comb begin
    next_state   = state;
    next_pending = pending + {4'h0, i_stored};
    next_cur     = o_cur;
    next_set_trq = 1'b0;
    next_set_idx = o_set_idx;
    if (!i_enable) begin
      next_state   = ST_IDLE;
      next_pending = ring_store_pkg::RST_PENDING;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_stored) begin
            next_state   = ST_BUSY;
            next_cur     = i_stored_idx;
            next_set_trq = 1'b1;
            next_set_idx = i_stored_idx;
          end
        end
        ST_BUSY: begin
          if (i_eval && i_cur_cleared) begin
            next_pending = next_pending - 5'h01;
            if (next_pending != 5'h00) begin
              next_cur     = o_cur + 4'h1;
              next_set_trq = 1'b1;
              next_set_idx = o_cur + 4'h1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= ST_IDLE;
      pending   <= ring_store_pkg::RST_PENDING;
      o_cur     <= ring_store_pkg::RST_PTR;
      o_set_trq <= 1'b0;
      o_set_idx <= ring_store_pkg::RST_PTR;
      o_busy    <= 1'b0;
    end else begin
      state     <= next_state;
      pending   <= next_pending;
      o_cur     <= next_cur;
      o_set_trq <= next_set_trq;
      o_set_idx <= next_set_idx;
      o_busy    <= (next_state == ST_BUSY);
    end
  end

  // **********************************************
  // checks
  // **********************************************
  property p_next_slot;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_enable && state == ST_BUSY && i_eval && i_cur_cleared && pending > 5'h01)
    |=> (o_set_trq && o_set_idx == $past(o_cur) + 4'h1);
  endproperty
  a_next_slot: assert property (p_next_slot)
    else $error("mirror engine did not advance to next slot");

  property p_eval_only;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state == ST_BUSY && !i_eval) |=> !o_set_trq;
  endproperty
  a_eval_only: assert property (p_eval_only)
    else $error("request raised without a clear event");

  property p_drained;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_enable && state == ST_BUSY && i_eval && i_cur_cleared
     && pending == 5'h01 && !i_stored) |=> (!o_busy && !o_set_trq);
  endproperty
  a_drained: assert property (p_drained)
    else $error("engine kept running with nothing pending");

endmodule // mirror_engine

// ===== verification/diag_partner.sv
// stand-in for the diagnosis channel: transmits each raised upper request
// assumes the ring store raises at most one upper request at a time
`timescale 1ns/1ps
module diag_partner #(
  parameter int DELAY = 5
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // request flags of buffers 32..47
  input  wire logic [15:0] i_trq,
  // transmit completion towards the ring store
  output logic             o_trq_clr,
  output logic             o_tx_done,
  output logic [5:0]       o_idx,
  // log of transmitted buffers
  output int               o_count,
  output logic [3:0][5:0]  o_seen
);
  int k;

  // ********************************************
  // transmit loop
  // ********************************************
  initial begin
    o_trq_clr = 1'b0;
    o_tx_done = 1'b0;
    o_idx     = 6'h2a;
    o_count   = 0;
    o_seen    = '0;
    forever begin
      @(posedge i_mclk);
      if (i_rst_n && (|i_trq)) begin
        repeat (DELAY) @(posedge i_mclk);
        for (k = 0; k < 16; k++) begin
          if (i_trq[k]) o_idx <= 6'(32 + k);
        end
        o_trq_clr <= 1'b1;
        o_tx_done <= 1'b1;
        @(posedge i_mclk);
        o_seen[o_count[1:0]] = o_idx;
        o_count = o_count + 1;
        o_trq_clr <= 1'b0;
        o_tx_done <= 1'b0;
        o_idx     <= ~o_idx;
        repeat (2) @(posedge i_mclk);
      end
    end
  end
endmodule // diag_partner

// ===== verification/tb_top.sv
// self-checking bench of the listen channel ring store
// assumes one 125 MHz clock and the register map of the package
`timescale 1ns/1ps
module tb_top;
  logic i_mclk, i_rst_n, wr_en, rd_en, rx_valid, reassign;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  ring_store_pkg::frame_t rx_frame;
  ring_store_pkg::store_t store;
  logic [15:0][2:0] assign_f;
  logic trq_clr, tx_done, rx_event;
  logic [5:0] p_idx;
  logic [15:0] new_data, transmit_request_flag;
  logic [3:0][5:0] seen;
  int n_mismatch, cmp_count, p_count, j;

  listen_channel_ring_store i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .o_rdata(rdata), .i_rx_valid(rx_valid), .i_rx_frame(rx_frame),
    .i_assign(assign_f), .i_reassign(reassign), .i_trq_clr(trq_clr),
    .i_trq_clr_idx(p_idx), .i_tx_done(tx_done), .i_tx_done_idx(p_idx),
    .o_store(store), .o_new_data(new_data), .o_trq(transmit_request_flag),
    .o_rx_event(rx_event));
  diag_partner i_partner (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_trq(transmit_request_flag),
    .o_trq_clr(trq_clr), .o_tx_done(tx_done), .o_idx(p_idx),
    .o_count(p_count), .o_seen(seen));

  // ********************************************
  // tasks
  // ********************************************
  task automatic chk(input logic [105:0] got, input logic [105:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge i_mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge i_mclk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask
  // sends frame number n; checks store, slot and receive event
  task automatic fr(input int n, input logic st, input logic [5:0] idx,
                    input logic ev);
    ring_store_pkg::frame_t f;
    f = '{ident: 29'h0abc_0000 + 29'(n), ext_ident: n[0], remote: n[1],
          length: n[3:0], data: {16{n[3:0]}}};
    @(posedge i_mclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge i_mclk);
    rx_valid <= 1'b0;
    #1;
    chk(store.valid, st);
    chk(rx_event, ev);
    if (st) begin
      chk(store.index, idx);
      chk(store.frame, f);
    end
  endtask

  // ********************************************
  // clock, reset, watchdog
  // ********************************************
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    #160000;
    n_mismatch++;
    end_of_test();
  end

  // ********************************************
  // main sequence
  // ********************************************
  initial begin
    {i_rst_n, wr_en, rd_en, rx_valid, reassign, n_mismatch, cmp_count} = '0;
    addr = 8'h00;
    wdata = 32'h0;
    rx_frame = '0;
    assign_f = {16{ring_store_pkg::ASSIGN_LISTEN}};
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(ring_store_pkg::REG_LAST, d);
    chk(d, 32'h0);
    rd(ring_store_pkg::REG_STORE_PTR, d);
    chk(d, 32'h20);
    wr(ring_store_pkg::REG_READY, 32'h0);
    wr(ring_store_pkg::REG_CTRL, 32'h1);
    wr(ring_store_pkg::REG_READY, 32'hffff);
    for (j = 0; j < 16; j++) fr(j, 1'b1, 6'(32 + j), 1'b1);
    chk(new_data, 16'hffff);
    rd(ring_store_pkg::REG_LAST, d);
    chk(d, 32'h2f);
    fr(16, 1'b0, 6'h0, 1'b0);
    rd(ring_store_pkg::REG_STATUS, d);
    chk(d[0], 1'b1);
    wr(ring_store_pkg::REG_NEW_DATA, 32'h20);
    fr(17, 1'b0, 6'h0, 1'b0);
    wr(ring_store_pkg::REG_NEW_DATA, 32'h1);
    wr(ring_store_pkg::REG_STATUS, 32'h1);
    fr(18, 1'b1, 6'h20, 1'b1);
    wr(ring_store_pkg::REG_CTRL, 32'h11);
    wr(ring_store_pkg::REG_CTRL, 32'h01);
    wr(ring_store_pkg::REG_NEW_DATA, 32'h6);
    fr(19, 1'b1, 6'h21, 1'b1);
    @(posedge i_mclk) assign_f[2] <= 3'h2;
    fr(20, 1'b0, 6'h0, 1'b0);
    @(posedge i_mclk) assign_f[2] <= ring_store_pkg::ASSIGN_LISTEN;
    rd(ring_store_pkg::REG_STATUS, d);
    chk(d[0], 1'b0);
    // reassign while the storing pointer sits away from the ring base
    @(posedge i_mclk);
    reassign <= 1'b1;
    @(posedge i_mclk);
    reassign <= 1'b0;
    rd(ring_store_pkg::REG_STORE_PTR, d);
    chk(d, 32'h20);
    wr(ring_store_pkg::REG_CTRL, 32'h21);
    rd(ring_store_pkg::REG_LAST, d);
    chk(d, 32'h21);
    wr(ring_store_pkg::REG_CTRL, 32'h0);
    rd(ring_store_pkg::REG_LAST, d);
    chk(d, 32'h0);
    rd(8'hfc, d);
    chk(d, 32'h0);
    // mirror: clear leftovers, then two frames one idle cycle apart
    wr(ring_store_pkg::REG_NEW_DATA, 32'hffff);
    wr(ring_store_pkg::REG_TRQ, 32'hffff);
    wr(ring_store_pkg::REG_CTRL, 32'h2);
    fr(21, 1'b1, 6'h20, 1'b0);
    chk(new_data[0], 1'b1);
    fr(22, 1'b1, 6'h21, 1'b0);
    chk(transmit_request_flag, 16'h0001);
    rd(ring_store_pkg::REG_STATUS, d);
    chk(d[2:1], 2'h3);
    repeat (60) @(posedge i_mclk);
    #1;
    chk(p_count, 2);
    chk(seen[0], 6'h20);
    chk(seen[1], 6'h21);
    chk(new_data, 16'h0);
    chk(transmit_request_flag, 16'h0);
    // mirror in OP_MIRROR_TIF, stored unfiltered: init exit restarts the ring at its base
    wr(ring_store_pkg::REG_CTRL, 32'h0);
    wr(ring_store_pkg::REG_CTRL, 32'h3);
    fr(23, 1'b1, 6'h20, 1'b0);
    repeat (30) @(posedge i_mclk);
    #1;
    chk(p_count, 3);
    chk(seen[2], 6'h20);
    chk(new_data, 16'h0);
    end_of_test();
  end
endmodule // tb_top
